/* File: hw/lcd_driver_reset_control.sv */
// Purpose: System reset, forced states and their release, and 1/10 duty
//          common timing of a dot-matrix LCD controller/driver.
// Assumes: Supply detector and inhibit pins are asynchronous levels;
//          key data arrive on the system clock.
// Notes:   Instructions are APB register writes; zero wait states.
// Functional notes
// [RQ1] Detector low supply or power-up resets system.
// [RQ2] Reset: display off, scan off, keys cleared.
// [RQ3] Reset locks output ports low until released.
// [RQ4] Display on only by display instruction.
// [RQ5] Display memories not initialized by reset.
// [RQ6] Host programs memories before display on.
// [RQ7] Host turns display off before power down.
// [RQ8] Key scan instruction enables scan, releases clear.
// [RQ9] Port instruction releases lock, sets levels.
// [RQ10] Reset forces oscillator to run.
// [RQ11] Reset initializes instruction register and decoder.
// [RQ12] Address counter loaded only by address instruction.
// [RQ13] Latch loaded when display instruction executes.
// [RQ14] Ten commons, 384 periods each, 3840 frame.
// [RQ15] Reset returns serial interface to input wait.
// [RQ16] Shared output is low segment during reset.
// [RQ17] Reset held while low, released on tick.
`timescale 1ns/1ns
module lcd_driver_reset_control #(
    parameter int OSC_DIV = lcd_reset_pkg::OSC_DIV_DEF
) (
    input  wire logic                     clk,
    input  wire logic                     rstn,
    input  wire logic                     supply_low_pin,
    input  wire logic                     display_inhibit_pin_n,
    input  wire lcd_reset_pkg::apb_req_s  apb_req,
    output lcd_reset_pkg::apb_rsp_s       apb_rsp,
    input  wire logic [29:0]              key_in,
    input  wire logic                     key_strobe,
    output logic                          system_reset,
    output logic                          osc_run,
    output logic                          instr_dec_init,
    output logic                          serial_wait,
    output logic                          display_en,
    output logic                          latch_load,
    output logic                          shared_is_common,
    output logic [9:0]                    common_outputs,
    output logic                          scan_en,
    output logic [5:0]                    key_scan_state,
    output logic                          key_clear,
    output logic [29:0]                   key_data,
    output logic [3:0]                    gp_port,
    output logic [5:0]                    address_counter
);

    localparam logic [7:0] DIV_LAST  = 8'(OSC_DIV - 1);
    localparam logic [8:0] SLOT_LAST = 9'(lcd_reset_pkg::COM_PERIODS - 1);
    localparam logic [3:0] COM_LAST  = 4'(lcd_reset_pkg::NUM_COMMONS - 1);

    typedef struct packed {
        logic [2:0]                 sync_low;
        logic [2:0]                 sync_inh;
        logic                       low_f;
        logic                       inh_f;
        logic                       por;
        logic                       in_reset;
        logic [7:0]                 div;
        logic                       tick;
        logic [8:0]                 slot;
        logic [3:0]                 com_idx;
        logic [9:0]                 common;
        logic                       disp_on;
        logic                       latch_valid;
        logic                       latch_load;
        logic                       shared_common;
        lcd_reset_pkg::duty_e       duty;
        logic                       scan_en;
        logic [5:0]                 ks;
        logic                       key_clr;
        logic [29:0]                key_data;
        logic                       port_lock;
        logic [3:0]                 port;
        logic [5:0]                 addr;
        logic [2:0]                 last_cmd;
        logic                       osc_run;
        logic                       serial_wait;
        logic                       pready;
        logic [31:0]                prdata;
        logic                       pslverr;
    } st_s;

    st_s st;
    st_s next_st;

    logic       setup;
    logic       access;
    logic       wr_ok;
    logic [2:0] sel;

    // Returns a register index, or CMD_NONE for an unmapped address.
    function automatic logic [2:0] reg_index(input logic [7:0] a);
        if (a == lcd_reset_pkg::OFS_DISP) begin
            return 3'h0;
        end else if (a == lcd_reset_pkg::OFS_TECH) begin
            return 3'h1;
        end else if (a == lcd_reset_pkg::OFS_KEYSCAN) begin
            return 3'h2;
        end else if (a == lcd_reset_pkg::OFS_PORT) begin
            return 3'h3;
        end else if (a == lcd_reset_pkg::OFS_ADDR) begin
            return 3'h4;
        end else if (a == lcd_reset_pkg::OFS_STATUS) begin
            return 3'h5;
        end else if (a == lcd_reset_pkg::OFS_KEYDATA) begin
            return 3'h6;
        end else begin
            return lcd_reset_pkg::CMD_NONE;
        end
    endfunction : reg_index

    function automatic logic [31:0] read_word(input st_s s,
                                              input logic [2:0] idx);
        case (idx)
            3'h0:    read_word = {31'h0000_0000, s.disp_on};
            3'h1:    read_word = {29'h0000_0000, s.shared_common, s.duty};
            3'h2:    read_word = {26'h000_0000, s.ks};
            3'h3:    read_word = {28'h000_0000, s.port};
            3'h4:    read_word = {26'h000_0000, s.addr};
            3'h5:    read_word = {17'h0_0000, s.last_cmd, s.com_idx,
                                  s.shared_common, s.osc_run,
                                  s.latch_valid, s.port_lock, s.key_clr,
                                  s.scan_en, s.disp_on, s.in_reset};
            3'h6:    read_word = {2'h0, s.key_data};
            default: read_word = 32'h0000_0000;
        endcase
    endfunction : read_word

    assign setup  = apb_req.psel && !apb_req.penable;
    assign access = apb_req.psel && apb_req.penable && st.pready;
    assign sel    = reg_index(apb_req.paddr);
    // Instructions are not executed while the system reset stands.
    assign wr_ok  = access && apb_req.pwrite && !st.in_reset
                    && sel != lcd_reset_pkg::CMD_NONE;

    always_comb begin
        next_st = st;
        next_st.sync_low = {st.sync_low[1:0], supply_low_pin};
        next_st.sync_inh = {st.sync_inh[1:0], display_inhibit_pin_n};
        if (st.sync_low[1] == st.sync_low[2]) begin
            next_st.low_f = st.sync_low[2];
        end
        if (st.sync_inh[1] == st.sync_inh[2]) begin
            next_st.inh_f = st.sync_inh[2];
        end

        next_st.tick = 1'b0;
        if (st.div == DIV_LAST) begin
            next_st.div  = 8'h00;
            next_st.tick = 1'b1;
        end else begin
            next_st.div = st.div + 8'h01;
        end

        // [RQ1] Reset entry request.
        if (st.por || st.low_f) begin
            next_st.in_reset = 1'b1;
        // [RQ17] Synchronous release on tick.
        end else if (st.tick) begin
            next_st.in_reset = 1'b0;
        end
        if (st.tick) begin
            next_st.por = 1'b0;
        end

        // [RQ14] Common slot sequencing.
        if (st.tick) begin
            if (st.slot == SLOT_LAST) begin
                next_st.slot    = 9'h000;
                next_st.com_idx = (st.com_idx == COM_LAST) ? 4'h0
                                  : st.com_idx + 4'h1;
            end else begin
                next_st.slot = st.slot + 9'h001;
            end
        end
        next_st.common = 10'h000;
        if (st.disp_on && st.duty == lcd_reset_pkg::DUTY_10) begin
            next_st.common = 10'(10'h001 << st.com_idx);
        end

        next_st.pready     = setup;
        next_st.latch_load = 1'b0;
        if (setup) begin
            next_st.prdata  = read_word(st, sel);
            next_st.pslverr = (sel == lcd_reset_pkg::CMD_NONE)
                              || (apb_req.pwrite && st.in_reset);
        end

        if (wr_ok) begin
            // [RQ11] Instruction register update.
            next_st.last_cmd    = sel;
            next_st.serial_wait = 1'b0;
            case (sel)
                3'h0: begin
                    // [RQ4] Display on/off control.
                    next_st.disp_on =
                        apb_req.pwdata[lcd_reset_pkg::DISP_ON_BIT];
                    // [RQ13] Latch load on display instruction.
                    next_st.latch_load  = 1'b1;
                    next_st.latch_valid = 1'b1;
                end
                3'h1: begin
                    // [RQ16] Technique selects shared output.
                    next_st.duty = lcd_reset_pkg::duty_e'(
                        apb_req.pwdata[lcd_reset_pkg::TECH_DUTY_LSB +: 2]);
                    next_st.shared_common =
                        apb_req.pwdata[lcd_reset_pkg::TECH_SHARED_BIT];
                end
                3'h2: begin
                    // [RQ8] Scan enable and clear release.
                    next_st.scan_en = 1'b1;
                    next_st.key_clr = 1'b0;
                    next_st.ks = apb_req.pwdata[lcd_reset_pkg::KEYSCAN_LSB
                                                +: lcd_reset_pkg::NUM_KS];
                end
                3'h3: begin
                    // [RQ9] Port lock release.
                    next_st.port_lock = 1'b0;
                    next_st.port = apb_req.pwdata[lcd_reset_pkg::PORT_LSB
                                                  +: lcd_reset_pkg::NUM_PORTS];
                end
                3'h4: begin
                    // [RQ12] Address counter load.
                    next_st.addr = apb_req.pwdata[lcd_reset_pkg::ADDR_LSB
                                                  +: lcd_reset_pkg::ADDR_W];
                end
                default: begin
                end
            endcase
        end

        if (key_strobe && st.scan_en && !st.key_clr) begin
            next_st.key_data = key_in;
        end

        // An asserted inhibit pin turns the display off like the instruction.
        if (!st.inh_f) begin
            next_st.disp_on = 1'b0;
        end

        // [RQ5] Memories left untouched.
        // Only control state is forced; memory contents stay as written.
        if (next_st.in_reset) begin
            // [RQ2] Forced display and key state.
            next_st.disp_on  = 1'b0;
            next_st.scan_en  = 1'b0;
            next_st.key_clr  = 1'b1;
            next_st.key_data = 30'h0000_0000;
            next_st.ks       = lcd_reset_pkg::KS_RST;
            // [RQ3] Ports locked low.
            next_st.port_lock = 1'b1;
            next_st.port      = lcd_reset_pkg::PORT_RST;
            // [RQ10] Oscillator forced on.
            next_st.osc_run = 1'b1;
            // [RQ11] Decoder initialized.
            next_st.last_cmd = lcd_reset_pkg::CMD_NONE;
            // [RQ12] Address counter cleared.
            next_st.addr = lcd_reset_pkg::ADDR_RST;
            // [RQ13] Latch content treated as invalid.
            next_st.latch_valid = 1'b0;
            // [RQ15] Serial input wait.
            next_st.serial_wait = 1'b1;
            // [RQ16] Shared output as segment.
            next_st.shared_common = 1'b0;
            next_st.duty          = lcd_reset_pkg::DUTY_8;
            next_st.slot    = 9'h000;
            next_st.com_idx = 4'h0;
            next_st.common  = 10'h000;
        end
    end

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            st             <= '0;
            st.sync_inh    <= 3'h7;
            st.inh_f       <= 1'b1;
            st.por         <= 1'b1;
            st.in_reset    <= 1'b1;
            st.key_clr     <= 1'b1;
            st.port_lock   <= 1'b1;
            st.osc_run     <= 1'b1;
            st.serial_wait <= 1'b1;
            st.last_cmd    <= lcd_reset_pkg::CMD_NONE;
        end else begin
            st <= next_st;
        end
    end

    assign apb_rsp.pready   = st.pready;
    assign apb_rsp.prdata   = st.prdata;
    assign apb_rsp.pslverr  = st.pslverr;
    assign system_reset     = st.in_reset;
    assign osc_run          = st.osc_run;
    assign instr_dec_init   = st.in_reset;
    assign serial_wait      = st.serial_wait;
    assign display_en       = st.disp_on;
    assign latch_load       = st.latch_load;
    assign shared_is_common = st.shared_common;
    assign common_outputs   = st.common;
    assign scan_en          = st.scan_en;
    assign key_scan_state   = st.ks;
    assign key_clear        = st.key_clr;
    assign key_data         = st.key_data;
    assign gp_port          = st.port;
    assign address_counter  = st.addr;

    default clocking dc @(posedge clk); endclocking
    default disable iff (!rstn);

    reset_entry_a: assert property ( // [RQ1]
        st.low_f |=> st.in_reset)
        else $error("low supply did not hold system reset");
    reset_forces_a: assert property ( // [RQ2]
        st.in_reset |-> !st.disp_on && !st.scan_en && st.key_data == '0)
        else $error("reset did not force display and keys off");
    port_lock_a: assert property ( // [RQ3]
        st.port_lock |-> gp_port == 4'h0)
        else $error("locked port not low");
    disp_cause_a: assert property ( // [RQ4]
        $rose(st.disp_on) |-> $past(wr_ok && sel == 3'h0))
        else $error("display turned on without instruction");
    scan_release_a: assert property ( // [RQ8]
        wr_ok && sel == 3'h2 |=> st.scan_en && !st.key_clr)
        else $error("key scan instruction not applied");
    port_release_a: assert property ( // [RQ9]
        wr_ok && sel == 3'h3 |=> !st.port_lock
            && gp_port == $past(apb_req.pwdata[3:0]))
        else $error("port instruction not applied");
    osc_forced_a: assert property ( // [RQ10]
        st.in_reset |-> st.osc_run && st.serial_wait)
        else $error("oscillator or serial wait not forced");
    addr_load_a: assert property ( // [RQ12]
        $changed(st.addr) |-> $past(wr_ok && sel == 3'h4) || st.in_reset)
        else $error("address counter changed without instruction");
    latch_load_a: assert property ( // [RQ13]
        wr_ok && sel == 3'h0 |=> latch_load ##1 !latch_load)
        else $error("latch load pulse missing");
    com_step_a: assert property ( // [RQ14]
        $changed(st.com_idx) && !st.in_reset |->
            $past(st.tick) && $past(st.slot) == SLOT_LAST)
        else $error("common advanced off the slot boundary");
    shared_seg_a: assert property ( // [RQ16]
        st.in_reset |-> !st.shared_common && common_outputs == 10'h000)
        else $error("shared output not a low segment in reset");
    release_tick_a: assert property ( // [RQ17]
        $fell(st.in_reset) |-> $past(st.tick) && !$past(st.low_f))
        else $error("reset released off the base clock tick");

    release_c: cover property ($fell(st.in_reset));
    display_on_c: cover property ($rose(st.disp_on));
    frame_wrap_c: cover property (
        st.com_idx == COM_LAST ##1 st.com_idx == 4'h0);
    port_free_c: cover property ($fell(st.port_lock));

endmodule : lcd_driver_reset_control

/* File: hw/lcd_reset_pkg.sv */
// Purpose: Shared constants and carrier types for the LCD driver reset
//          and initialization control block.
// Assumes: APB with 32-bit data; one word per register.
// Notes:   Timing counts are in base clock periods (one divider tick).
package lcd_reset_pkg;

    // Register byte offsets.
    localparam logic [7:0] OFS_DISP    = 8'h00;
    localparam logic [7:0] OFS_TECH    = 8'h04;
    localparam logic [7:0] OFS_KEYSCAN = 8'h08;
    localparam logic [7:0] OFS_PORT    = 8'h0C;
    localparam logic [7:0] OFS_ADDR    = 8'h10;
    localparam logic [7:0] OFS_STATUS  = 8'h14;
    localparam logic [7:0] OFS_KEYDATA = 8'h18;

    // Field positions.
    localparam int DISP_ON_BIT     = 0;
    localparam int TECH_DUTY_LSB   = 0;
    localparam int TECH_SHARED_BIT = 2;
    localparam int KEYSCAN_LSB     = 0;
    localparam int PORT_LSB        = 0;
    localparam int ADDR_LSB        = 0;

    // Widths and reset values.
    localparam int NUM_PORTS = 4;
    localparam int NUM_KS    = 6;
    localparam int NUM_KEYS  = 30;
    localparam int ADDR_W    = 6;
    localparam logic [3:0] PORT_RST    = 4'h0;
    localparam logic [5:0] ADDR_RST    = 6'h00;
    localparam logic [5:0] KS_RST      = 6'h00;
    localparam logic [2:0] CMD_NONE    = 3'h7;

    // Common timing: periods per common, commons per frame.
    localparam int COM_PERIODS   = 384;
    localparam int NUM_COMMONS   = 10;
    localparam int FRAME_PERIODS = COM_PERIODS * NUM_COMMONS;
    // System clock cycles per base clock period.
    localparam int OSC_DIV_DEF   = 8;

    typedef enum logic [1:0] {DUTY_8, DUTY_9, DUTY_10} duty_e;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [7:0]  paddr;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic        pready;
        logic [31:0] prdata;
        logic        pslverr;
    } apb_rsp_s;

endpackage : lcd_reset_pkg

/* File: tb/host_apb_model.sv */
// Purpose: Host model that issues instructions to the block as APB
//          transfers.
// Assumes: The slave may add wait states; the bench calls the tasks.
// Notes:   A transfer that never sees pready sets timed_out.
`timescale 1ns/1ns
module host_apb_model (
    input  wire lcd_reset_pkg::apb_rsp_s rsp,
    input  wire logic                    clk,
    output lcd_reset_pkg::apb_req_s      req,
    output logic                         timed_out
);
    logic [31:0] rdata;
    logic        err;

    initial begin
        req       = '0;
        timed_out = 1'b0;
    end

    // The request is held from setup until the edge that samples pready.
    task automatic xfer(input logic wr, input logic [7:0] addr,
                        input logic [31:0] wdata,
                        output logic [31:0] rd, output logic er);
        int n;
        n = 0;
        @(posedge clk);
        req <= '{1'b1, 1'b0, wr, addr, wdata};
        @(posedge clk);
        req.penable <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (rsp.pready !== 1'b1 && n < 64);
        if (rsp.pready !== 1'b1) timed_out = 1'b1;
        rd = rsp.prdata;
        er = rsp.pslverr;
        req.psel    <= 1'b0;
        req.penable <= 1'b0;
    endtask : xfer

    // Ordered start-up.
    // Memory writes travel on a path outside this block, so only the
    // technique and the address counter precede display on here.
    task automatic setup_display(input logic [31:0] tech,
                                 input logic [31:0] addr);
        xfer(1'b1, lcd_reset_pkg::OFS_TECH, tech, rdata, err);
        xfer(1'b1, lcd_reset_pkg::OFS_ADDR, addr, rdata, err);
    endtask : setup_display

    task automatic power_down;
        xfer(1'b1, lcd_reset_pkg::OFS_DISP, 32'h0000_0000, rdata, err);
    endtask : power_down
endmodule : host_apb_model

/* File: tb/lcd_driver_reset_control_test.sv */
// Purpose: Self-checking bench for reset, forced states and commons.
// Assumes: OSC_DIV shortened to 2, so one common lasts 768 clocks.
// Notes:   Instructions reach the block only through the host model.
`timescale 1ns/1ns
module lcd_driver_reset_control_test;
    localparam int DIV = 2;
    localparam logic [7:0] STS = lcd_reset_pkg::OFS_STATUS;
    logic                    clk = 1'b0;
    logic                    rstn = 1'b0;
    logic                    supply_low_pin = 1'b0;
    logic                    display_inhibit_pin_n = 1'b1;
    logic [29:0]             key_in = '0;
    logic                    key_strobe = 1'b0;
    lcd_reset_pkg::apb_req_s apb_req;
    lcd_reset_pkg::apb_rsp_s apb_rsp;
    logic                    system_reset, osc_run, instr_dec_init;
    logic                    serial_wait, display_en, latch_load;
    logic                    shared_is_common, scan_en, key_clear;
    logic                    timed_out, err;
    logic [9:0]              common_outputs;
    logic [5:0]              key_scan_state, address_counter;
    logic [29:0]             key_data;
    logic [3:0]              gp_port;
    logic [31:0]             rdata;
    int                      errors = 0;
    int                      checked = 0;
    int                      loads = 0;

    lcd_driver_reset_control #(.OSC_DIV(DIV)) u_lcd_driver_reset_control (
        .clk(clk), .rstn(rstn), .supply_low_pin(supply_low_pin),
        .display_inhibit_pin_n(display_inhibit_pin_n), .apb_req(apb_req),
        .apb_rsp(apb_rsp), .key_in(key_in), .key_strobe(key_strobe),
        .system_reset(system_reset), .osc_run(osc_run),
        .instr_dec_init(instr_dec_init), .serial_wait(serial_wait),
        .display_en(display_en), .latch_load(latch_load),
        .shared_is_common(shared_is_common),
        .common_outputs(common_outputs), .scan_en(scan_en),
        .key_scan_state(key_scan_state), .key_clear(key_clear),
        .key_data(key_data), .gp_port(gp_port),
        .address_counter(address_counter));

    host_apb_model u_host_apb_model (
        .rsp(apb_rsp), .clk(clk), .req(apb_req), .timed_out(timed_out));

    always #20 clk = ~clk;

    always @(posedge clk) begin
        if (latch_load === 1'b1) loads <= loads + 1;
    end

    task automatic give_verdict;
        $display("checks %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h seen %h", what, exp, got);
            errors++;
        end
    endtask : chk

    // Results are read at the falling edge, after the access edge landed.
    task automatic bus(input logic wr, input logic [7:0] a,
                       input logic [31:0] d, input logic experr);
        u_host_apb_model.xfer(wr, a, d, rdata, err);
        if (timed_out === 1'b1) begin
            errors++;
            give_verdict();
        end
        chk("pslverr", experr, err);
        @(negedge clk);
    endtask : bus

    task automatic rd(input logic [7:0] a, input logic [31:0] mask,
                      input logic [31:0] exp);
        bus(1'b0, a, 32'h0000_0000, 1'b0);
        chk("read data", exp, rdata & mask);
    endtask : rd

    task automatic wait_sys(input logic lvl, input int lim);
        int n;
        n = 0;
        while (system_reset !== lvl && n < lim) begin
            @(posedge clk);
            n++;
        end
        chk("system_reset", lvl, system_reset);
        if (system_reset !== lvl) give_verdict();
    endtask : wait_sys

    task automatic strobe(input logic [29:0] v);
        @(posedge clk);
        key_in     <= v;
        key_strobe <= 1'b1;
        @(posedge clk);
        key_strobe <= 1'b0;
        @(posedge clk);
        @(negedge clk);
    endtask : strobe

    task automatic com_frame;
        logic [9:0] prev;
        logic [9:0] want;
        int         n;
        int         total;
        total = 0;
        for (int k = 0; k <= 10; k++) begin
            prev = common_outputs;
            want = {prev[8:0], prev[9]};
            n = 0;
            do begin
                @(posedge clk);
                n++;
            end while (common_outputs === prev && n < 2000);
            if (k > 0) begin
                total += n;
                chk("common period", 384 * DIV, n);
                chk("common order", want, common_outputs);
            end
        end
        chk("frame length", 3840 * DIV, total);
    endtask : com_frame

    initial begin
        repeat (19) @(posedge clk);
        chk("key_clear", 1'b1, key_clear);
        chk("osc_run", 1'b1, osc_run);
        chk("decoder init", 2'h3, {system_reset, instr_dec_init});
        chk("serial_wait", 1'b1, serial_wait);
        chk("forced outs", 0, {display_en, scan_en, gp_port});
        chk("address_counter", 0, address_counter);
        chk("shared outs", 0, {shared_is_common, common_outputs});
        @(posedge clk);
        rstn <= 1'b1;
        wait_sys(1'b0, 2 * DIV + 2);
        rd(STS, 32'h0000_70FF, 32'h0000_7058);
        $display("test reset done");

        strobe(30'h1234_5678);
        chk("key_data", 0, key_data);
        bus(1'b1, lcd_reset_pkg::OFS_KEYSCAN, 32'h0000_003C, 1'b0);
        chk("scan flags", 2'b10, {scan_en, key_clear});
        chk("serial_wait", 1'b0, serial_wait);
        chk("key_scan_state", 6'h3C, key_scan_state);
        strobe(30'h1234_5678);
        rd(lcd_reset_pkg::OFS_KEYDATA, 32'hFFFF_FFFF, 32'h1234_5678);
        chk("gp_port locked", 4'h0, gp_port);
        bus(1'b1, lcd_reset_pkg::OFS_PORT, 32'h0000_000A, 1'b0);
        chk("gp_port", 4'hA, gp_port);
        bus(1'b1, lcd_reset_pkg::OFS_PORT, 32'h0000_0005, 1'b0);
        chk("gp_port", 4'h5, gp_port);
        rd(STS, 32'h0000_0010, 32'h0000_0000);
        $display("test release done");

        u_host_apb_model.setup_display(32'h0000_0006, 32'h0000_002B);
        @(negedge clk);
        chk("address_counter", 6'h2B, address_counter);
        chk("shared common", 1'b1, shared_is_common);
        chk("display before on", 0, {display_en, common_outputs});
        bus(1'b1, lcd_reset_pkg::OFS_DISP, 32'h0000_0001, 1'b0);
        repeat (2) @(negedge clk);
        chk("display_en", 1'b1, display_en);
        chk("latch loads", 1, loads);
        com_frame();
        chk("address kept", 6'h2B, address_counter);
        $display("test commons done");

        display_inhibit_pin_n <= 1'b0;
        for (int n = 0; n < 12 && display_en !== 1'b0; n++) @(posedge clk);
        // The commons follow the display flag one clock later.
        @(negedge clk);
        chk("inhibit display", 0, {display_en, common_outputs});
        @(posedge clk);
        display_inhibit_pin_n <= 1'b1;
        // The pin filter needs four edges before the display may come on.
        repeat (4) @(posedge clk);
        bus(1'b1, lcd_reset_pkg::OFS_DISP, 32'h0000_0001, 1'b0);
        @(negedge clk);
        chk("display again", 1'b1, display_en);
        chk("latch loads", 2, loads);
        u_host_apb_model.power_down();
        repeat (2) @(negedge clk);
        chk("power down", 0, {display_en, common_outputs});
        chk("latch loads", 3, loads);
        $display("test display off done");

        @(posedge clk);
        supply_low_pin <= 1'b1;
        wait_sys(1'b1, 8);
        chk("key_data", 0, key_data);
        chk("low flags", 3'b001, {display_en, scan_en, key_clear});
        chk("low shared", 1'b0, shared_is_common);
        chk("low ports", 0, gp_port);
        chk("low address", 0, address_counter);
        chk("low commons", 0, common_outputs);
        bus(1'b1, lcd_reset_pkg::OFS_PORT, 32'h0000_000F, 1'b1);
        repeat (40) @(posedge clk);
        chk("held reset", 1'b1, system_reset);
        supply_low_pin <= 1'b0;
        wait_sys(1'b0, 4 * DIV + 8);
        rd(STS, 32'h0000_70FF, 32'h0000_7058);
        bus(1'b0, 8'h1C, 32'h0000_0000, 1'b1);
        chk("unmapped read", 0, rdata);
        $display("test supply drop done");
        give_verdict();
    end
endmodule : lcd_driver_reset_control_test
